// ### src/iam_pkg.sv
package iam_pkg;
  localparam int AVS_AW = 3;
  localparam int AVS_DW = 32;
  // Word indices of the registers
  localparam logic [AVS_AW-1:0] REG_CTRL = 3'h0;
  localparam logic [AVS_AW-1:0] REG_ADDR = 3'h1;
  localparam logic [AVS_AW-1:0] REG_STATUS = 3'h2;
  localparam logic [AVS_AW-1:0] REG_INTFLAG = 3'h3;
  localparam logic [AVS_AW-1:0] REG_INTMASK = 3'h4;
  // Control fields
  localparam int CTRL_TWO_ADDR = 0;
  localparam int CTRL_WIDE = 1;
  // Address register fields
  localparam int ADDR_VAL_LSB = 0;
  localparam int AUTO_LENGTH_COUNT_LSB = 8;
  localparam int ADDR_MASK_LSB = 16;
  // Status fields
  localparam int ST_BUS_ERROR_FLAG = 0;
  localparam int ST_ARBITRATION_LOST_FLAG = 1;
  localparam int ST_RECEIVED_NACK_FLAG = 2;
  localparam int ST_BUSST_LSB = 4;
  localparam int ST_SCL_LOW_TIMEOUT_FLAG = 6;
  localparam int ST_CLOCK_HOLD_FLAG = 7;
  localparam int ST_MEXT = 8;
  localparam int ST_SEXT = 9;
  localparam int ST_LENGTH_ERROR_FLAG = 10;
  // Interrupt flag and mask fields
  localparam int IRQ_N = 5;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_LENGTH_ERROR_FLAG = 1;
  localparam int IRQ_SEXT = 2;
  localparam int IRQ_MEXT = 3;
  localparam int IRQ_SCL_LOW_TIMEOUT_FLAG = 4;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [IRQ_N-1:0] IMASK_RST = 5'h00;
  // Time-out limits
  localparam int CLK_MHZ = 100;
  localparam int LOW_TOUT_US = 25000;
  localparam int SEXT_TOUT_US = 25000;
  localparam int MEXT_TOUT_US = 10000;
  localparam int LOW_TOUT_CYC = LOW_TOUT_US * CLK_MHZ;
  localparam int SEXT_TOUT_CYC = SEXT_TOUT_US * CLK_MHZ;
  localparam int MEXT_TOUT_CYC = MEXT_TOUT_US * CLK_MHZ;
  localparam int TOUT_CNT_W = 22;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_BUSY = 2'b10} iam_bus_e;
endpackage

// ### src/iam_addr_match.sv
`timescale 1ns/10ps
module iam_addr_match
  import iam_pkg::*;
(
  input wire logic [7:0] addr_in,
  input wire logic [7:0] match_val,
  input wire logic [7:0] match_mask_field,
  input wire logic two_addr,
  input wire logic wide,
  output logic hit
);
  logic [7:0] cmp;
  logic [7:0] diff_a;
  logic [7:0] diff_b;

  assign cmp = wide ? 8'hff : 8'h7f;

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      // Masked bits never count as a difference outside two-address mode
      assign diff_a[i] = cmp[i] & (addr_in[i] ^ match_val[i]) & (two_addr | ~match_mask_field[i]);
      assign diff_b[i] = cmp[i] & (addr_in[i] ^ match_mask_field[i]);
    end
  endgenerate

  assign hit = (diff_a == 8'h00) | (two_addr & (diff_b == 8'h00));
endmodule

// ### src/iam_scl_mon.sv
`timescale 1ns/10ps
module iam_scl_mon
  import iam_pkg::*;
#(
  parameter int CNT_W = TOUT_CNT_W,
  parameter int LOW_CYC = LOW_TOUT_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic scl_s,
  output logic start_p,
  output logic stop_p,
  output logic low_tout_p,
  output logic busy
);
  logic [1:0] scl_sync_q, scl_sync_d;
  logic [1:0] sda_sync_q, sda_sync_d;
  logic scl_old_q, sda_old_q;
  logic [CNT_W-1:0] low_cnt_q, low_cnt_d;
  iam_bus_e bus_q, bus_d;
  logic sda_s;

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign start_p = scl_s & scl_old_q & sda_old_q & ~sda_s;
  assign stop_p = scl_s & scl_old_q & ~sda_old_q & sda_s;
  assign low_tout_p = ~scl_s & (low_cnt_q == CNT_W'(LOW_CYC - 1));
  assign busy = (bus_q == BUS_BUSY);

  always_comb
  begin
    scl_sync_d = {scl_sync_q[0], scl_pin};
    sda_sync_d = {sda_sync_q[0], sda_pin};
    // Saturates so the time-out fires once per low period
    if (scl_s)
      low_cnt_d = '0;
    else if (low_cnt_q == CNT_W'(LOW_CYC))
      low_cnt_d = low_cnt_q;
    else
      low_cnt_d = low_cnt_q + CNT_W'(1);
    case (bus_q)
      BUS_IDLE: bus_d = start_p ? BUS_BUSY : BUS_IDLE;
      BUS_BUSY: bus_d = (stop_p | low_tout_p) ? BUS_IDLE : BUS_BUSY;
      default: bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_old_q <= 1'b1;
      sda_old_q <= 1'b1;
      low_cnt_q <= '0;
      bus_q <= BUS_IDLE;
    end
    else
    begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      scl_old_q <= scl_s;
      sda_old_q <= sda_s;
      low_cnt_q <= low_cnt_d;
      bus_q <= bus_d;
    end
  end
endmodule

// ### src/iam_top.sv
`timescale 1ns/10ps
module iam_top
  import iam_pkg::*;
#(
  parameter int CNT_W = TOUT_CNT_W,
  parameter int LOW_CYC = LOW_TOUT_CYC,
  parameter int SEXT_CYC = SEXT_TOUT_CYC,
  parameter int MEXT_CYC = MEXT_TOUT_CYC
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [AVS_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [AVS_DW-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [AVS_DW-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic [7:0] RX_ADDR,
  input wire logic RX_ADDR_VALID,
  input wire logic BYTE_SENT,
  input wire logic NACK_RX,
  input wire logic DMA_AUTO_LEN,
  input wire logic MASTER_SCL_LOW,
  input wire logic HOLD_REQ,
  input wire logic MB_FLAG,
  input wire logic SB_FLAG,
  input wire logic NEXT_CMD,
  input wire logic ARB_LOST,
  input wire logic BUS_ERROR,
  output logic ADDR_MATCH,
  output logic IRQ
);
  // Bus slave state
  logic wait_q, wait_d;
  logic [AVS_DW-1:0] rdata_q, rdata_d;
  // Software registers
  logic [1:0] ctrl_q, ctrl_d;
  logic [7:0] match_q, match_d;
  logic [7:0] len_q, len_d;
  logic [7:0] amask_q, amask_d;
  logic [IRQ_N-1:0] imask_q, imask_d;
  logic [IRQ_N-1:0] iflag_q, iflag_d;
  // Bus status flags
  logic length_error_flag_q, length_error_flag_d;
  logic sext_q, sext_d;
  logic mext_q, mext_d;
  logic hold_q, hold_d;
  logic lowt_q, lowt_d;
  logic received_nack_flag_q, received_nack_flag_d;
  logic arb_q, arb_d;
  logic berr_q, berr_d;
  logic hit_q, hit_d;
  logic irq_q, irq_d;
  // Counters
  logic [7:0] bcnt_q, bcnt_d;
  logic [CNT_W-1:0] scnt_q, scnt_d;
  logic [CNT_W-1:0] mcnt_q, mcnt_d;

  logic scl_s, start_p, stop_p, low_tout_p, busy;
  logic hit;
  logic [AVS_DW-1:0] wmask, w1c;
  logic wr_go, rd_take;
  logic ctrl_wr, addr_wr, st_wr, if_wr, im_wr;
  logic [15:0] status;
  logic [8:0] bcnt_inc;
  logic length_error_flag_ev, sext_ev, mext_ev;
  logic [IRQ_N-1:0] iev;

  iam_scl_mon #(
    .CNT_W(CNT_W),
    .LOW_CYC(LOW_CYC)
  ) u_mon (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .scl_pin(SCL_IN),
    .sda_pin(SDA_IN),
    .scl_s(scl_s),
    .start_p(start_p),
    .stop_p(stop_p),
    .low_tout_p(low_tout_p),
    .busy(busy)
  );

  iam_addr_match u_match (
    .addr_in(RX_ADDR),
    .match_val(match_q),
    .match_mask_field(amask_q),
    .two_addr(ctrl_q[CTRL_TWO_ADDR]),
    .wide(ctrl_q[CTRL_WIDE]),
    .hit(hit)
  );

  // Bus slave: one wait cycle, then the request completes
  assign wr_go = AVS_WRITE & ~wait_q;
  assign rd_take = AVS_READ & wait_q;
  assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                  {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign w1c = AVS_WRITEDATA & wmask;
  assign ctrl_wr = wr_go & (AVS_ADDRESS == REG_CTRL);
  assign addr_wr = wr_go & (AVS_ADDRESS == REG_ADDR);
  assign st_wr = wr_go & (AVS_ADDRESS == REG_STATUS);
  assign if_wr = wr_go & (AVS_ADDRESS == REG_INTFLAG);
  assign im_wr = wr_go & (AVS_ADDRESS == REG_INTMASK);

  always_comb
  begin
    status = 16'h0000;
    status[ST_LENGTH_ERROR_FLAG] = length_error_flag_q;
    status[ST_SEXT] = sext_q;
    status[ST_MEXT] = mext_q;
    status[ST_CLOCK_HOLD_FLAG] = hold_q;
    status[ST_SCL_LOW_TIMEOUT_FLAG] = lowt_q;
    status[ST_BUSST_LSB +: 2] = busy ? BUS_BUSY : BUS_IDLE;
    status[ST_RECEIVED_NACK_FLAG] = received_nack_flag_q;
    status[ST_ARBITRATION_LOST_FLAG] = arb_q;
    status[ST_BUS_ERROR_FLAG] = berr_q;
  end

  always_comb
  begin
    wait_d = ~((AVS_READ | AVS_WRITE) & wait_q);
    rdata_d = rdata_q;
    if (rd_take)
    begin
      case (AVS_ADDRESS)
        REG_CTRL: rdata_d = {30'h0, ctrl_q};
        REG_ADDR: rdata_d = {8'h00, amask_q, len_q, match_q};
        REG_STATUS: rdata_d = {16'h0000, status};
        REG_INTFLAG: rdata_d = {27'h0, iflag_q};
        REG_INTMASK: rdata_d = {27'h0, imask_q};
        // Unmapped words read as zero
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Byte and extension counters
  assign bcnt_inc = {1'b0, bcnt_q} + {8'h00, BYTE_SENT};
  assign sext_ev = ~scl_s & ~MASTER_SCL_LOW & busy & (scnt_q == CNT_W'(SEXT_CYC - 1));
  assign mext_ev = MASTER_SCL_LOW & (mcnt_q == CNT_W'(MEXT_CYC - 1));
  assign length_error_flag_ev = NACK_RX & DMA_AUTO_LEN & (bcnt_inc < {1'b0, len_q});

  always_comb
  begin
    bcnt_d = bcnt_q;
    if (addr_wr | start_p)
      bcnt_d = BYTE_RST;
    else if (BYTE_SENT & (bcnt_q != 8'hff))
      bcnt_d = bcnt_inc[7:0];
    // Slave stretching is summed over the whole frame
    scnt_d = scnt_q;
    if (start_p | stop_p)
      scnt_d = '0;
    else if (~scl_s & ~MASTER_SCL_LOW & busy & (scnt_q != CNT_W'(SEXT_CYC)))
      scnt_d = scnt_q + CNT_W'(1);
    // Master stretching is summed per byte
    mcnt_d = mcnt_q;
    if (start_p | BYTE_SENT)
      mcnt_d = '0;
    else if (MASTER_SCL_LOW & (mcnt_q != CNT_W'(MEXT_CYC)))
      mcnt_d = mcnt_q + CNT_W'(1);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      bcnt_q <= 8'h00;
      scnt_q <= '0;
      mcnt_q <= '0;
    end
    else
    begin
      bcnt_q <= bcnt_d;
      scnt_q <= scnt_d;
      mcnt_q <= mcnt_d;
    end
  end

  // Registers and flags; a set in the same cycle as a clear wins
  always_comb
  begin
    ctrl_d = ctrl_wr ? w1c[1:0] | (ctrl_q & ~wmask[1:0]) : ctrl_q;
    match_d = match_q;
    len_d = len_q;
    amask_d = amask_q;
    if (addr_wr)
    begin
      match_d = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[ADDR_VAL_LSB +: 8] : match_q;
      len_d = AVS_BYTEENABLE[1] ? AVS_WRITEDATA[AUTO_LENGTH_COUNT_LSB +: 8] : len_q;
      amask_d = AVS_BYTEENABLE[2] ? AVS_WRITEDATA[ADDR_MASK_LSB +: 8] : amask_q;
    end
    imask_d = im_wr ? (w1c[IRQ_N-1:0] | (imask_q & ~wmask[IRQ_N-1:0])) : imask_q;
    // Flag writes act directly in this clock domain
    length_error_flag_d = length_error_flag_ev | (length_error_flag_q & ~addr_wr & ~(st_wr & w1c[ST_LENGTH_ERROR_FLAG]));
    sext_d = sext_ev | (sext_q & ~addr_wr & ~(st_wr & w1c[ST_SEXT]));
    mext_d = mext_ev | (mext_q & ~addr_wr & ~(st_wr & w1c[ST_MEXT]));
    lowt_d = low_tout_p | (lowt_q & ~(st_wr & w1c[ST_SCL_LOW_TIMEOUT_FLAG]));
    arb_d = ARB_LOST | (arb_q & ~(st_wr & w1c[ST_ARBITRATION_LOST_FLAG]));
    berr_d = BUS_ERROR | (berr_q & ~(st_wr & w1c[ST_BUS_ERROR_FLAG]));
    received_nack_flag_d = NACK_RX | (received_nack_flag_q & ~BYTE_SENT);
    // Bus writes never touch the hold bit
    hold_d = HOLD_REQ | (hold_q & ~(~MB_FLAG & ~SB_FLAG & NEXT_CMD));
    hit_d = RX_ADDR_VALID & hit;
    iev = '0;
    iev[IRQ_MATCH] = hit_d;
    iev[IRQ_LENGTH_ERROR_FLAG] = length_error_flag_ev;
    iev[IRQ_SEXT] = sext_ev;
    iev[IRQ_MEXT] = mext_ev;
    iev[IRQ_SCL_LOW_TIMEOUT_FLAG] = low_tout_p;
    iflag_d = iev | (iflag_q & ~(if_wr ? w1c[IRQ_N-1:0] : '0));
    // Output lags the flag by one cycle so it stays a clean flop
    irq_d = |(iflag_q & imask_q);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      ctrl_q <= CTRL_RST;
      match_q <= BYTE_RST;
      len_q <= BYTE_RST;
      amask_q <= BYTE_RST;
      imask_q <= IMASK_RST;
      iflag_q <= '0;
      length_error_flag_q <= 1'b0;
      sext_q <= 1'b0;
      mext_q <= 1'b0;
      lowt_q <= 1'b0;
      arb_q <= 1'b0;
      berr_q <= 1'b0;
      received_nack_flag_q <= 1'b0;
      hold_q <= 1'b0;
      hit_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      match_q <= match_d;
      len_q <= len_d;
      amask_q <= amask_d;
      imask_q <= imask_d;
      iflag_q <= iflag_d;
      length_error_flag_q <= length_error_flag_d;
      sext_q <= sext_d;
      mext_q <= mext_d;
      lowt_q <= lowt_d;
      arb_q <= arb_d;
      berr_q <= berr_d;
      received_nack_flag_q <= received_nack_flag_d;
      hold_q <= hold_d;
      hit_q <= hit_d;
      irq_q <= irq_d;
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign ADDR_MATCH = hit_q;
  assign IRQ = irq_q;
endmodule

// ### tb/iam_top_monitor.sv
`timescale 1ns/10ps
module iam_top_monitor
  import iam_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [AVS_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [AVS_DW-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [AVS_DW-1:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [7:0] RX_ADDR,
  input wire logic RX_ADDR_VALID,
  input wire logic ADDR_MATCH,
  input wire logic IRQ
);
  logic [1:0] ctl_q, ctl_d;
  logic [23:0] adr_q, adr_d;
  logic [4:0] msk_q, msk_d;
  logic wr_ok;
  logic [7:0] wm;
  logic hit;
  // Shadows follow full-word writes only; partial lanes would need a byte model
  always_comb
  begin
    wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE == 4'hf;
    ctl_d = (wr_ok && AVS_ADDRESS == REG_CTRL) ? AVS_WRITEDATA[1:0] : ctl_q;
    adr_d = (wr_ok && AVS_ADDRESS == REG_ADDR) ? AVS_WRITEDATA[23:0] : adr_q;
    msk_d = (wr_ok && AVS_ADDRESS == REG_INTMASK) ? AVS_WRITEDATA[4:0] : msk_q;
    wm = ctl_q[1] ? 8'hff : 8'h7f;
    hit = ctl_q[0] ? (((RX_ADDR ^ adr_q[7:0]) & wm) == 8'h00 || ((RX_ADDR ^ adr_q[23:16]) & wm) == 8'h00)
      : (((RX_ADDR ^ adr_q[7:0]) & ~adr_q[23:16] & wm) == 8'h00);
  end
  always_ff @(posedge REF_CLK)
  begin
    ctl_q <= RST_N ? ctl_d : 2'h0;
    adr_q <= RST_N ? adr_d : 24'h000000;
    msk_q <= RST_N ? msk_d : 5'h00;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_wait_one:
    assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Request not answered in one cycle");
  a_wait_pulse:
    assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("Answer longer than one cycle");
  a_match_exp:
    assert property (RX_ADDR_VALID |=> ADDR_MATCH == $past(hit))
    else $error("Address match wrong");
  a_match_idle:
    assert property (!RX_ADDR_VALID |=> !ADDR_MATCH)
    else $error("Match without address");
  a_irq_masked:
    assert property (msk_q == 5'h00 && $past(msk_q) == 5'h00 |-> !IRQ)
    else $error("Interrupt while all masked");
  a_irq_cause:
    assert property ($rose(IRQ) |-> $past(msk_q) != 5'h00)
    else $error("Interrupt rose with zero mask");
  a_rd_ctrl:
    assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == REG_CTRL |-> AVS_READDATA[1:0] == ctl_q)
    else $error("Mode readback wrong");
  a_rd_addr:
    assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == REG_ADDR |-> AVS_READDATA[23:0] == adr_q)
    else $error("Address readback wrong");
endmodule

bind iam_top iam_top_monitor u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX_ADDR(RX_ADDR),
  .RX_ADDR_VALID(RX_ADDR_VALID), .ADDR_MATCH(ADDR_MATCH), .IRQ(IRQ));

// ### tb/iam_i2c_peer.sv
`timescale 1ns/10ps
module iam_i2c_peer (
  output logic scl,
  output logic sda
);
  // Pull-ups: released lines idle high, clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Frame of nb bits, then the slave stretches SCL low for st ns
  task automatic frame(input int nb, input int st);
    // Step off the sampling edge so the synchroniser never races the pins
    #3;
    sda = 1'b0;
    #80;
    for (int i = 0; i < nb; i++)
    begin
      scl = 1'b0;
      sda = i[0];
      #80;
      scl = 1'b1;
      #80;
    end
    scl = 1'b0;
    #(st);
    sda = 1'b0;
    #80;
    scl = 1'b1;
    #80;
    sda = 1'b1;
    #80;
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  import iam_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, dv = 1'b0, bs = 1'b0, nk = 1'b0;
  logic dma = 1'b0, msl = 1'b0, hq = 1'b0, mb = 1'b0, nc = 1'b0, sb = 1'b0, arb = 1'b0, ber = 1'b0;
  logic [2:0] adr = 3'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [7:0] ra = 8'h00;
  logic wq, am, irq, scl, sda;
  int err_count = 0, tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  iam_i2c_peer u_peer (.scl(scl), .sda(sda));
  // Short time-outs keep the run brief
  iam_top #(.LOW_CYC(20), .SEXT_CYC(30), .MEXT_CYC(15)) u_dut (.REF_CLK(ref_clk), .RST_N(rst_n),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .SCL_IN(scl), .SDA_IN(sda), .RX_ADDR(ra), .RX_ADDR_VALID(dv),
    .BYTE_SENT(bs), .NACK_RX(nk), .DMA_AUTO_LEN(dma), .MASTER_SCL_LOW(msl), .HOLD_REQ(hq), .MB_FLAG(mb),
    .SB_FLAG(sb), .NEXT_CMD(nc), .ARB_LOST(arb), .BUS_ERROR(ber), .ADDR_MATCH(am), .IRQ(irq));
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task summarize;
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Values read at the edge come before that edge's updates land
  task acc(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // Only the watchdog ends a wait that never sees an answer
    do
    begin
      @(posedge ref_clk);
    end
    while (wq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rs(input logic [31:0] m, input logic [31:0] e);
    acc(1'b0, REG_STATUS, 32'h0);
    chk(q & m, e);
  endtask
  task mt(input logic [1:0] c, input logic [23:0] a, input logic [7:0] x, input logic e);
    acc(1'b1, REG_CTRL, {30'h0, c});
    acc(1'b1, REG_ADDR, {8'h00, a});
    @(posedge ref_clk);
    ra <= x;
    dv <= 1'b1;
    @(posedge ref_clk);
    dv <= 1'b0;
    @(posedge ref_clk);
    chk({31'h0, am}, {31'h0, e});
  endtask
  task pz(input logic b, input logic k);
    @(posedge ref_clk);
    bs <= b;
    nk <= k;
    @(posedge ref_clk);
    bs <= 1'b0;
    nk <= 1'b0;
  endtask
  task pn;
    @(posedge ref_clk);
    nc <= 1'b1;
    @(posedge ref_clk);
    nc <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b0, 3'(i), 32'h0);
      chk(q, i == 2 ? 32'h10 : 32'h0);
    end
    mt(2'h2, 24'h00005a, 8'h5a, 1'h1);
    mt(2'h2, 24'h00005a, 8'h5b, 1'h0);
    mt(2'h2, 24'h03005a, 8'h59, 1'h1);
    mt(2'h2, 24'h03005a, 8'h5e, 1'h0);
    mt(2'h2, 24'hff005a, 8'ha5, 1'h1);
    mt(2'h0, 24'h00005a, 8'hda, 1'h1);
    mt(2'h2, 24'h00005a, 8'hda, 1'h0);
    mt(2'h3, 24'h33005a, 8'h33, 1'h1);
    mt(2'h3, 24'h33005a, 8'h5a, 1'h1);
    mt(2'h3, 24'h33005a, 8'h34, 1'h0);
    acc(1'b1, REG_ADDR, 32'h35a);
    fork
      u_peer.frame(8, 400);
      begin
        repeat (20) @(posedge ref_clk);
        rs(32'h30, 32'h20);
      end
    join
    rs(32'h7f0, 32'h250);
    @(posedge ref_clk);
    msl <= 1'b1;
    repeat (20) @(posedge ref_clk);
    msl <= 1'b0;
    pz(1'b0, 1'b1);
    rs(32'h7c4, 32'h344);
    dma <= 1'b1;
    pz(1'b1, 1'b0);
    pz(1'b0, 1'b1);
    rs(32'h7c4, 32'h744);
    acc(1'b0, REG_INTFLAG, 32'h0);
    chk(q, 32'h1f);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, REG_INTMASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, REG_INTFLAG, 32'h1f);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, REG_STATUS, 32'h0);
    rs(32'h7c0, 32'h740);
    acc(1'b1, REG_STATUS, 32'h400);
    rs(32'h7c0, 32'h340);
    acc(1'b1, REG_STATUS, 32'h100);
    rs(32'h7c0, 32'h240);
    acc(1'b1, REG_ADDR, 32'h35a);
    rs(32'h7c0, 32'h040);
    pz(1'b0, 1'b1);
    rs(32'h7c0, 32'h440);
    acc(1'b1, REG_ADDR, 32'h35a);
    rs(32'h7c0, 32'h040);
    pz(1'b1, 1'b0);
    pz(1'b1, 1'b0);
    pz(1'b1, 1'b1);
    rs(32'h7c0, 32'h040);
    acc(1'b1, REG_STATUS, 32'h40);
    rs(32'h7c0, 32'h0);
    @(posedge ref_clk);
    arb <= 1'b1;
    ber <= 1'b1;
    @(posedge ref_clk);
    arb <= 1'b0;
    ber <= 1'b0;
    rs(32'h3, 32'h3);
    acc(1'b1, REG_STATUS, 32'h1);
    rs(32'h3, 32'h2);
    acc(1'b1, REG_STATUS, 32'h2);
    rs(32'h3, 32'h0);
    @(posedge ref_clk);
    hq <= 1'b1;
    mb <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rs(32'h80, 32'h80);
    acc(1'b1, REG_STATUS, 32'h80);
    rs(32'h80, 32'h80);
    hq <= 1'b0;
    pn();
    rs(32'h80, 32'h80);
    mb <= 1'b0;
    pn();
    rs(32'h80, 32'h0);
    hq <= 1'b1;
    sb <= 1'b1;
    @(posedge ref_clk);
    hq <= 1'b0;
    pn();
    rs(32'h80, 32'h80);
    sb <= 1'b0;
    pn();
    rs(32'h80, 32'h0);
    summarize();
  end
endmodule
